// File: hdl/lsnp_pkg.sv
package lsnp_pkg;

    // ---------------------------------------------------------------
    // Snooped I/O addresses
    // ---------------------------------------------------------------
    localparam logic [15:0] LSNP_ADDR_KBD_RELEASE   = 16'h0060;
    localparam logic [15:0] LSNP_ADDR_APM_COMMAND   = 16'h00b2;
    localparam logic [15:0] LSNP_ADDR_APM_STATUS    = 16'h00b3;
    localparam logic [15:0] LSNP_ADDR_FPU_CLEAR     = 16'h00f0;
    localparam logic [15:0] LSNP_ADDR_FLOPPY_PRI    = 16'h03f2;
    localparam logic [15:0] LSNP_ADDR_FLOPPY_SEC    = 16'h0372;
    localparam logic [15:0] LSNP_ADDR_TRIG_LOW      = 16'h04d0;
    localparam logic [15:0] LSNP_ADDR_TRIG_HIGH     = 16'h04d1;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int          LSNP_FLOPPY_DMA_EN_BIT  = 3;
    localparam int          LSNP_SMI_SOURCE_ENABLE_REG_APM_BIT      = 7;
    localparam int          LSNP_SMICTL_SMI_BIT     = 0;
    localparam int          LSNP_SMICTL_STOP_BIT    = 1;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  LSNP_RST_APM_COMMAND    = 8'h00;
    localparam logic [7:0]  LSNP_RST_APM_STATUS     = 8'h00;
    localparam logic [7:0]  LSNP_RST_TRIG           = 8'h00;
    localparam logic        LSNP_RST_FLOPPY_DMA_EN  = 1'b0;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } lsnp_io_req_s;

    typedef struct packed {
        logic       mouse_en;
        logic       fpu_err_en;
        logic [7:0] smi_source_enable_reg;
        logic [7:0] smi_control_reg;
    } lsnp_cfg_s;

endpackage : lsnp_pkg

// File: hdl/lsnp_regs.sv
// Function
// [RULE_01] Floppy output port at 3F2h or 372h is write-only; keep bit 3.
// [RULE_02] With bit 3 set, DMA channel 2 acknowledge drives transceiver enable.
// [RULE_03] Floppy DMA enable bit resets to 0.
// [RULE_04] Snooped accesses also pass through to the ISA bus.
// [RULE_05] Any read of 60h releases the keyboard interrupt; here a keyboard request in the same cycle wins and keeps it set.
// [RULE_06] Mouse enabled: mouse input raises interrupt, read of 60h releases it.
// [RULE_07] Mouse disabled: reads of 60h leave mouse interrupt untouched.
// [RULE_08] Error reporting enabled: coprocessor error raises interrupt 13.
// [RULE_09] Write F0h during error asserts ignore-error and drops interrupt 13.
// [RULE_10] Ignore-error holds until the error input negates.
// [RULE_11] Write F0h without error leaves ignore-error unchanged.
// [RULE_12] Two 8-bit trigger-select registers; 1 level, 0 edge per interrupt.
// [RULE_13] Trigger-select registers reset to zero.
// [RULE_14] Software keeps interrupts 0,1,2,8,13 edge sensitive.
// [RULE_15] Software sets PCI-steered interrupts level sensitive.
// [RULE_16] Power-management ports take single-byte accesses only.
// [RULE_17] Command port 0B2h read/write, resets 00h, returns last write.
// [RULE_18] Command write raises SYS_MGMT_IRQ only if enable bit 7 and control bit 0.
// [RULE_19] Command read stops CPU clock if control bit 1; never SYS_MGMT_IRQ.
// [RULE_20] Status port 0B3h read/write, resets 00h, no effect on behaviour.
// [RULE_21] Mouse, coprocessor, SYS_MGMT_IRQ enable and control bits arrive as inputs.
`timescale 1ns/100ps
module lsnp_regs
(
    input  wire logic                  core_clk,              // 25 MHz clock
    input  wire logic                  rst_n,                 // Sync reset, active low
    input  wire logic                  clk_en,                // Freezes state when low
    input  wire lsnp_pkg::lsnp_io_req_s io_req,               // Byte I/O cycle, one-cycle strobe
    input  wire lsnp_pkg::lsnp_cfg_s   cfg,                   // Configuration bits
    input  wire logic                  dma_ch2_ack_n,         // DMA channel 2 acknowledge
    input  wire logic                  keyboard_irq_in,       // Keyboard controller request
    input  wire logic                  mouse_irq_input,       // Mouse request
    input  wire logic                  fpu_error_in_n,        // Coprocessor error
    output logic [7:0]                 io_rdata,              // Read data
    output logic                       io_claim,              // Device returns read data
    output logic                       isa_forward,           // Cycle passes to ISA
    output logic                       util_bus_xcvr_oe_n,    // Transceiver enable
    output logic                       keyboard_irq,          // Latched keyboard interrupt
    output logic                       mouse_irq,             // Latched mouse interrupt; raw pin when mouse disabled
    output logic                       fpu_error_irq,         // Interrupt 13
    output logic                       ignore_fpu_error_n,    // Ignore coprocessor error
    output logic                       sys_mgmt_irq,          // SYS_MGMT_IRQ pulse
    output logic                       cpu_clock_stop_n,      // CPU clock stop
    output logic [15:0]                trigger_select         // Per-interrupt level select
);
    import lsnp_pkg::*;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic hit_kbd;
    logic hit_cmd;
    logic hit_sts;
    logic hit_fpu;
    logic hit_flp;
    logic hit_tlo;
    logic hit_thi;
    logic rd_kbd;
    logic wr_fpu;
    logic fpu_err;

    assign hit_kbd = (io_req.addr == LSNP_ADDR_KBD_RELEASE);
    assign hit_cmd = (io_req.addr == LSNP_ADDR_APM_COMMAND);
    assign hit_sts = (io_req.addr == LSNP_ADDR_APM_STATUS);
    assign hit_fpu = (io_req.addr == LSNP_ADDR_FPU_CLEAR);
    assign hit_flp = (io_req.addr == LSNP_ADDR_FLOPPY_PRI)
                   || (io_req.addr == LSNP_ADDR_FLOPPY_SEC);     // RULE_01
    assign hit_tlo = (io_req.addr == LSNP_ADDR_TRIG_LOW);
    assign hit_thi = (io_req.addr == LSNP_ADDR_TRIG_HIGH);
    assign rd_kbd  = clk_en && io_req.rd && hit_kbd;
    assign wr_fpu  = clk_en && io_req.wr && hit_fpu;
    assign fpu_err = !fpu_error_in_n;

    // Passive snoop: every cycle flows through, even to owned ports
    assign isa_forward = io_req.rd || io_req.wr;                  // RULE_04

    // ---------------------------------------------------------------
    // Configuration inputs
    // ---------------------------------------------------------------
    // Levels from the bridge configuration registers
    logic mouse_on;
    logic fpu_on;
    logic smi_armed;
    logic stop_armed;

    assign mouse_on   = cfg.mouse_en;                             // RULE_21
    assign fpu_on     = cfg.fpu_err_en;                           // RULE_21
    assign smi_armed  = cfg.smi_source_enable_reg[LSNP_SMI_SOURCE_ENABLE_REG_APM_BIT]
                      && cfg.smi_control_reg[LSNP_SMICTL_SMI_BIT]; // RULE_18 RULE_21
    assign stop_armed = cfg.smi_control_reg[LSNP_SMICTL_STOP_BIT]; // RULE_21

    // ---------------------------------------------------------------
    // Accepted cycles
    // ---------------------------------------------------------------
    // Strobes qualified by the clock enable
    logic rd_cmd;
    logic wr_cmd;
    logic rd_own;

    assign rd_cmd = clk_en && io_req.rd && hit_cmd;
    assign wr_cmd = clk_en && io_req.wr && hit_cmd;
    // Only readable ports answer; reads of 60h, F0h and floppy port do not
    assign rd_own = clk_en && io_req.rd && (hit_cmd || hit_sts || hit_tlo || hit_thi);

    // ---------------------------------------------------------------
    // Floppy DMA gate
    // ---------------------------------------------------------------
    logic floppy_dma_en_reg;

    // Only the DMA enable bit of the floppy port is kept
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            floppy_dma_en_reg <= LSNP_RST_FLOPPY_DMA_EN;          // RULE_03
        else if (clk_en && io_req.wr && hit_flp)
            floppy_dma_en_reg <= io_req.wdata[LSNP_FLOPPY_DMA_EN_BIT]; // RULE_01
    end

    assign util_bus_xcvr_oe_n = !(floppy_dma_en_reg && !dma_ch2_ack_n); // RULE_02

    // ---------------------------------------------------------------
    // Keyboard and mouse interrupt latches
    // ---------------------------------------------------------------
    logic kbd_irq_reg;
    logic mouse_irq_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            kbd_irq_reg <= 1'b0;
        else if (clk_en)
        begin
            if (keyboard_irq_in)
                kbd_irq_reg <= 1'b1;                              // Set wins over release
            else if (rd_kbd)
                kbd_irq_reg <= 1'b0;                              // RULE_05
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mouse_irq_reg <= 1'b0;
        else if (clk_en)
        begin
            if (!mouse_on)
                mouse_irq_reg <= mouse_irq_reg;                   // RULE_07
            else if (mouse_irq_input)
                mouse_irq_reg <= 1'b1;                            // RULE_06
            else if (rd_kbd)
                mouse_irq_reg <= 1'b0;                            // RULE_06
        end
    end

    assign keyboard_irq = kbd_irq_reg;
    // Mouse disabled: pin passes straight through, untouched by 60h
    assign mouse_irq    = mouse_on ? mouse_irq_reg : mouse_irq_input; // RULE_07

    // ---------------------------------------------------------------
    // Coprocessor error handling
    // ---------------------------------------------------------------
    logic ignore_fpu_error_n_reg;
    logic fpu_error_irq_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ignore_fpu_error_n_reg <= 1'b0;
        else if (clk_en)
        begin
            if (!fpu_err)
                ignore_fpu_error_n_reg <= 1'b0;                                // RULE_10
            else if (wr_fpu && fpu_on)
                ignore_fpu_error_n_reg <= 1'b1;                                // RULE_09 RULE_11
        end
    end

    // Interrupt 13 stays low while ignore-error is asserted
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            fpu_error_irq_reg <= 1'b0;
        else if (clk_en)
            fpu_error_irq_reg <= fpu_on && fpu_err && !ignore_fpu_error_n_reg
                         && !(wr_fpu && fpu_err);                 // RULE_08 RULE_09
    end

    assign fpu_error_irq      = fpu_error_irq_reg;
    assign ignore_fpu_error_n = !ignore_fpu_error_n_reg;

    // ---------------------------------------------------------------
    // Trigger-select registers
    // ---------------------------------------------------------------
    logic [7:0] trig_low_reg;
    logic [7:0] trig_high_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            trig_low_reg  <= LSNP_RST_TRIG;                       // RULE_13
            trig_high_reg <= LSNP_RST_TRIG;                       // RULE_13
        end
        else if (clk_en && io_req.wr)
        begin
            if (hit_tlo)
                trig_low_reg <= io_req.wdata;                     // RULE_12
            if (hit_thi)
                trig_high_reg <= io_req.wdata;                    // RULE_12
        end
    end

    // High register carries interrupts 8 to 15
    assign trigger_select = {trig_high_reg, trig_low_reg};        // RULE_12

    // ---------------------------------------------------------------
    // Power-management ports
    // ---------------------------------------------------------------
    logic [7:0] apm_command_port_reg;
    logic [7:0] apm_status_port_reg;
    logic       smi_reg;
    logic       stop_reg;

    // Byte-wide ports only; the bus carries single bytes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            apm_command_port_reg <= LSNP_RST_APM_COMMAND;         // RULE_17
            apm_status_port_reg  <= LSNP_RST_APM_STATUS;          // RULE_20
        end
        else if (clk_en && io_req.wr)
        begin
            if (hit_cmd)
                apm_command_port_reg <= io_req.wdata;             // RULE_17 RULE_16
            if (hit_sts)
                apm_status_port_reg <= io_req.wdata;              // RULE_20 RULE_16
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            smi_reg <= 1'b0;
        else if (clk_en)
            // Raised by command writes only, never by reads
            smi_reg <= wr_cmd && smi_armed;                       // RULE_18 RULE_19
    end

    // Clock stop holds until software clears the control bit
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            stop_reg <= 1'b0;
        else if (clk_en)
        begin
            if (!stop_armed)
                stop_reg <= 1'b0;
            else if (rd_cmd)
                stop_reg <= 1'b1;                                 // RULE_19
        end
    end

    assign sys_mgmt_irq     = smi_reg;
    assign cpu_clock_stop_n = !stop_reg;

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic       claim_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            claim_reg <= 1'b0;
        else if (clk_en)
            claim_reg <= rd_own;
    end

    // Data holds until the next accepted cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_reg <= 8'h00;
        else if (clk_en && (io_req.rd || io_req.wr))
        begin
            case (1'b1)
                hit_cmd: rdata_reg <= apm_command_port_reg;       // RULE_17
                hit_sts: rdata_reg <= apm_status_port_reg;        // RULE_20
                hit_tlo: rdata_reg <= trig_low_reg;               // RULE_12
                hit_thi: rdata_reg <= trig_high_reg;              // RULE_12
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign io_rdata = rdata_reg;
    assign io_claim = claim_reg;

endmodule : lsnp_regs

// File: verification/lsnp_host.sv
`timescale 1ns/100ps
module lsnp_host
(
    input  wire logic              core_clk, // Clock
    output lsnp_pkg::lsnp_io_req_s io_req    // I/O cycle
);
    import lsnp_pkg::*;
    initial io_req = '0;
    // Single byte per cycle, strobe held one clock
    task automatic cyc(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_req <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge core_clk);
        io_req <= '0;
    endtask : cyc
endmodule : lsnp_host

// File: verification/lsnp_regs_props.sv
`timescale 1ns/100ps
module lsnp_regs_props
(
    input wire logic                   core_clk,           // Clock
    input wire logic                   rst_n,              // Reset
    input wire logic                   clk_en,             // Run
    input wire lsnp_pkg::lsnp_io_req_s io_req,             // Cycle
    input wire lsnp_pkg::lsnp_cfg_s    cfg,                // Config
    input wire logic                   dma_ch2_ack_n,      // Ack
    input wire logic                   keyboard_irq_in,    // Kbd in
    input wire logic                   mouse_irq_input,    // Mouse in
    input wire logic                   fpu_error_in_n,     // Error in
    input wire logic                   isa_forward,        // Pass
    input wire logic                   util_bus_xcvr_oe_n, // Xcvr
    input wire logic                   keyboard_irq,       // Kbd
    input wire logic                   mouse_irq,          // Mouse
    input wire logic                   fpu_error_irq,      // Irq 13
    input wire logic                   ignore_fpu_error_n, // Ignore
    input wire logic                   sys_mgmt_irq,       // Smi
    input wire logic                   cpu_clock_stop_n    // Stop
);
    import lsnp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_ok = clk_en && io_req.rd;
    wire logic wr_ok = clk_en && io_req.wr;
    wire logic cmd   = io_req.addr == LSNP_ADDR_APM_COMMAND;
    wire logic f0    = io_req.addr == LSNP_ADDR_FPU_CLEAR;
    wire logic smi_on = cfg.smi_source_enable_reg[LSNP_SMI_SOURCE_ENABLE_REG_APM_BIT]
                        && cfg.smi_control_reg[LSNP_SMICTL_SMI_BIT];
    chk_xcvr_gate: assert property (dma_ch2_ack_n |-> util_bus_xcvr_oe_n)
        else $error("transceiver enabled without ack");
    chk_isa_pass: assert property (isa_forward == (io_req.rd || io_req.wr))
        else $error("cycle not forwarded");
    chk_kbd_release: assert property (rd_ok && !keyboard_irq_in
        && io_req.addr == LSNP_ADDR_KBD_RELEASE |=> !keyboard_irq) else $error("kbd held");
    chk_mouse_pass: assert property (!cfg.mouse_en |-> mouse_irq == mouse_irq_input)
        else $error("mouse altered");
    chk_fpu_error_irq_raise: assert property (clk_en && cfg.fpu_err_en && !fpu_error_in_n
        && ignore_fpu_error_n && !(wr_ok && f0) |=> fpu_error_irq) else $error("no fpu_error_irq");
    chk_ignore_set: assert property (wr_ok && f0 && cfg.fpu_err_en && !fpu_error_in_n
        |=> !ignore_fpu_error_n && !fpu_error_irq) else $error("ignore not set");
    chk_ignore_hold: assert property (!ignore_fpu_error_n && !fpu_error_in_n
        |=> !ignore_fpu_error_n) else $error("ignore dropped");
    chk_ignore_free: assert property (clk_en && fpu_error_in_n |=> ignore_fpu_error_n)
        else $error("ignore without error");
    chk_smi_gate: assert property (clk_en && !(wr_ok && cmd && smi_on)
        |=> !sys_mgmt_irq) else $error("stray smi");
    chk_smi_fire: assert property (wr_ok && cmd && smi_on |=> sys_mgmt_irq)
        else $error("smi missing");
    chk_stop_read: assert property (rd_ok && cmd
        && cfg.smi_control_reg[LSNP_SMICTL_STOP_BIT] |=> !cpu_clock_stop_n) else $error("no stop");
endmodule : lsnp_regs_props

bind lsnp_regs lsnp_regs_props lsnp_regs_props_i
(
    .core_clk, .rst_n, .clk_en, .io_req, .cfg, .dma_ch2_ack_n, .keyboard_irq_in,
    .mouse_irq_input, .fpu_error_in_n, .isa_forward, .util_bus_xcvr_oe_n, .keyboard_irq,
    .mouse_irq, .fpu_error_irq, .ignore_fpu_error_n, .sys_mgmt_irq, .cpu_clock_stop_n
);

// File: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import lsnp_pkg::*;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0, clk_en = 1'b1;
    lsnp_io_req_s io_req;
    lsnp_cfg_s    cfg = '0;
    logic         dma_ch2_ack_n = 1'b1, keyboard_irq_in = 1'b0;
    logic         mouse_irq_input = 1'b0, fpu_error_in_n = 1'b1;
    logic [7:0]   io_rdata;
    logic [15:0]  trigger_select, trig;
    logic         io_claim, isa_forward, util_bus_xcvr_oe_n, keyboard_irq, mouse_irq;
    logic         fpu_error_irq, ignore_fpu_error_n, sys_mgmt_irq, cpu_clock_stop_n;
    int           err_count = 0, samples_checked = 0, cycles = 0;
    logic [7:0]   exp_q[$];
    logic [31:0]  seed = 32'd25625;

    lsnp_regs lsnp_regs_i
    (
        .core_clk, .rst_n, .clk_en, .io_req, .cfg, .dma_ch2_ack_n, .keyboard_irq_in,
        .mouse_irq_input, .fpu_error_in_n, .io_rdata, .io_claim, .isa_forward,
        .util_bus_xcvr_oe_n, .keyboard_irq, .mouse_irq, .fpu_error_irq, .ignore_fpu_error_n,
        .sys_mgmt_irq, .cpu_clock_stop_n, .trigger_select
    );
    lsnp_host lsnp_host_i (.core_clk, .io_req);

    always #20 core_clk = ~core_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        lsnp_host_i.cyc(1'b1, a, 8'h00);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        lsnp_host_i.cyc(1'b0, a, d);
        @(negedge core_clk);
    endtask : wr

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // Read data checker, oldest note first
    // ---------------------------------------------------------------
    always @(negedge core_clk)
        if (io_claim === 1'b1)
            chk(io_rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        dma_ch2_ack_n <= 1'b0;
        @(negedge core_clk);
        chk(util_bus_xcvr_oe_n, 1'b1);
        chk(trigger_select, 16'h0000);
        rd(LSNP_ADDR_APM_COMMAND, LSNP_RST_APM_COMMAND);
        rd(LSNP_ADDR_APM_STATUS, LSNP_RST_APM_STATUS);
        rd(LSNP_ADDR_TRIG_HIGH, LSNP_RST_TRIG);
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(LSNP_ADDR_TRIG_LOW, 8'hff);
        clk_en <= 1'b1;
        chk(trigger_select, 16'h0000);
        wr(LSNP_ADDR_FLOPPY_PRI, 8'h08);
        chk(util_bus_xcvr_oe_n, 1'b0);
        lsnp_host_i.cyc(1'b1, LSNP_ADDR_FLOPPY_PRI, 8'h00);
        wr(LSNP_ADDR_FLOPPY_SEC, 8'hf7);
        chk(util_bus_xcvr_oe_n, 1'b1);
        $display("floppy and reset test done");
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            trig = seed[15:0] & 16'hdef8;
            wr(LSNP_ADDR_TRIG_LOW, trig[7:0]);
            wr(LSNP_ADDR_TRIG_HIGH, trig[15:8]);
            rd(LSNP_ADDR_TRIG_LOW, trig[7:0]);
            rd(LSNP_ADDR_TRIG_HIGH, trig[15:8]);
            chk(trigger_select, trig);
            cfg.smi_source_enable_reg <= {i[1], 7'h00};
            cfg.smi_control_reg <= {7'h00, i[0]};
            wr(LSNP_ADDR_APM_COMMAND, seed[23:16]);
            chk(sys_mgmt_irq, i == 3);
            rd(LSNP_ADDR_APM_COMMAND, seed[23:16]);
        end
        cfg.smi_control_reg <= 8'h03;
        wr(LSNP_ADDR_APM_STATUS, 8'ha5);
        chk(sys_mgmt_irq, 1'b0);
        rd(LSNP_ADDR_APM_STATUS, 8'ha5);
        rd(LSNP_ADDR_APM_COMMAND, seed[23:16]);
        @(negedge core_clk);
        chk({cpu_clock_stop_n, sys_mgmt_irq}, 2'b00);
        $display("trigger and power test done");
        @(posedge core_clk);
        cfg <= '{mouse_en: 1'b1, fpu_err_en: 1'b1, default: '0};
        {keyboard_irq_in, mouse_irq_input} <= 2'b11;
        @(posedge core_clk);
        {keyboard_irq_in, mouse_irq_input} <= 2'b00;
        @(negedge core_clk);
        chk({keyboard_irq, mouse_irq}, 2'b11);
        lsnp_host_i.cyc(1'b1, LSNP_ADDR_KBD_RELEASE, 8'h00);
        @(negedge core_clk);
        chk({keyboard_irq, mouse_irq}, 2'b00);
        cfg.mouse_en <= 1'b0;
        mouse_irq_input <= 1'b1;
        wr(LSNP_ADDR_FPU_CLEAR, 8'h00);
        chk({keyboard_irq, mouse_irq, ignore_fpu_error_n}, 3'b011);
        lsnp_host_i.cyc(1'b1, LSNP_ADDR_KBD_RELEASE, 8'h00);
        fpu_error_in_n <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk({mouse_irq, fpu_error_irq}, 2'b11);
        wr(LSNP_ADDR_FPU_CLEAR, seed[7:0]);
        repeat (3) @(negedge core_clk);
        chk({ignore_fpu_error_n, fpu_error_irq}, 2'b00);
        @(posedge core_clk);
        fpu_error_in_n <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk(ignore_fpu_error_n, 1'b1);
        chk(16'(exp_q.size()), 16'h0000);
        $display("interrupt test done");
        final_report();
    end
endmodule : tb_top
